// ==== rtl/sds_pkg.sv ====
package sds_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int READY_DELAY_MS = 100;
  localparam int READY_DELAY_CYC = CLK_HZ / 1000 * READY_DELAY_MS;
  localparam int ENC_LINES = 1000;
  localparam int ENC_CPR = 4 * ENC_LINES;
  localparam int STEPS_PER_REV = 1000;
  localparam int THR_DECI_DEG = 64;
  localparam int DECI_DEG_PER_REV = 3600;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_STEP_POS = 8'h14;
  localparam logic [7:0] OFS_ENC_POS = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic stall_monitor_en;
    logic step_scheme_sel;
  } sds_ctrl_type;
  localparam sds_ctrl_type CTRL_RESET = 2'h2;
  typedef struct packed {
    logic ready_rise;
    logic temp_fault;
    logic contour_err;
  } sds_evt_type;
  localparam sds_evt_type EVT_RESET = 3'h0;
endpackage : sds_pkg

// ==== rtl/sds_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sds_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  // Level moves only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end
  assign level = level_reg;
endmodule : sds_pin_sync
`default_nettype wire

// ==== rtl/sds_quad_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module sds_quad_dec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chan_a,
  input wire logic chan_b,
  output logic inc,
  output logic dec
);
  logic [1:0] prev_reg;
  logic [1:0] cur;
  logic [3:0] trans;
  assign cur = {chan_a, chan_b};
  assign trans = {prev_reg, cur};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 2'h0;
    end else begin
      prev_reg <= cur;
    end
  end
  // A leading B counts up; double jumps are dropped as noise
  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    unique case (trans)
      4'h2, 4'hB, 4'hD, 4'h4: inc = 1'b1;
      4'h1, 4'h7, 4'hE, 4'h8: dec = 1'b1;
      default: ;
    endcase
  end
endmodule : sds_quad_dec
`default_nettype wire

// ==== rtl/sds_step_dir_monitor.sv ====
// Functional notes
// - Step lines read as step-plus-direction or forward/backward, by CTRL bit.
// - Step-plus-direction: one step per rising edge of the step line.
// - Direction low or open means clockwise, high means anticlockwise.
// - Forward/backward: forward rise steps clockwise, backward rise anticlockwise.
// - Amplifier enabled only while the enable input is high.
// - Without fault, ready shows about 100 ms after amplifier enable.
// - Ready output is active low: low when enabled, released when disabled.
// - A second ready output carries the inverse level.
// - Reserved output is held low at all times.
// - Encoder position tracked incrementally, up or down by rotation.
// - Contouring error when encoder deviates from setpoint by over 6.4 deg.
// - Clearing the monitor enable suppresses contouring error reports.
// - Winding temperature low means overheat or cable break: a fault.
`timescale 1ns/1ps
`default_nettype none
module sds_step_dir_monitor #(
  parameter int READY_DELAY_CYC = sds_pkg::READY_DELAY_CYC,
  parameter int STEPS_PER_REV = sds_pkg::STEPS_PER_REV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fwd_step_in_p,
  input wire logic fwd_step_in_n,
  input wire logic rev_step_in_p,
  input wire logic rev_step_in_n,
  input wire logic enable_in_p,
  input wire logic enable_in_n,
  input wire logic enc_a_p,
  input wire logic enc_a_n,
  input wire logic enc_b_p,
  input wire logic enc_b_n,
  input wire logic winding_temp_ok,
  output logic amp_en_out,
  output logic ready_n_out,
  output logic ready_n_oe,
  output logic drive_ready_pos,
  output logic reserved_out,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = 64;
  localparam logic signed [PW-1:0] ENC_CPR_W = PW'(sds_pkg::ENC_CPR);
  localparam logic signed [PW-1:0] SPR_W = PW'(STEPS_PER_REV);
  localparam logic signed [PW-1:0] DDEG_W =
    PW'(sds_pkg::DECI_DEG_PER_REV);
  localparam logic signed [PW-1:0] LIMIT_W =
    ENC_CPR_W * SPR_W * PW'(sds_pkg::THR_DECI_DEG);
  localparam logic [31:0] READY_LAST = 32'(READY_DELAY_CYC - 1);

  logic fwd_q;
  logic rev_q;
  logic enable_q;
  logic enc_a_q;
  logic enc_b_q;
  logic temp_q;
  logic enc_inc;
  logic enc_dec;

  // Open pair (both low) reads as low
  sds_pin_sync u_fwd (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(fwd_step_in_p & ~fwd_step_in_n), .level(fwd_q));
  sds_pin_sync u_rev (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(rev_step_in_p & ~rev_step_in_n), .level(rev_q));
  sds_pin_sync u_enable (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(enable_in_p & ~enable_in_n), .level(enable_q));
  sds_pin_sync u_enc_a (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(enc_a_p & ~enc_a_n), .level(enc_a_q));
  sds_pin_sync u_enc_b (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(enc_b_p & ~enc_b_n), .level(enc_b_q));
  sds_pin_sync u_temp (
    .aclk(aclk), .aresetn(aresetn),
    .pin_in(winding_temp_ok), .level(temp_q));

  sds_quad_dec u_quad (
    .aclk(aclk), .aresetn(aresetn), .chan_a(enc_a_q),
    .chan_b(enc_b_q), .inc(enc_inc), .dec(enc_dec));

  sds_pkg::sds_ctrl_type ctrl_reg;
  sds_pkg::sds_evt_type status_reg;
  sds_pkg::sds_evt_type irq_en_reg;
  sds_pkg::sds_evt_type clear_pulse;
  sds_pkg::sds_evt_type evt;
  logic fwd_prev_reg;
  logic rev_prev_reg;
  logic fwd_rise;
  logic rev_rise;
  logic amp_en_reg;
  logic contour_err_reg;
  logic fault;
  logic signed [31:0] step_pos_reg;
  logic signed [31:0] enc_pos_reg;
  logic [31:0] ready_cnt_reg;
  logic ready_reg;
  logic ready_next;
  logic signed [PW-1:0] dev;
  logic signed [PW-1:0] dev_abs;
  logic over;

  assign fwd_rise = fwd_q & ~fwd_prev_reg;
  assign rev_rise = rev_q & ~rev_prev_reg;
  assign fault = ~temp_q | contour_err_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_prev_reg <= 1'b0;
      rev_prev_reg <= 1'b0;
    end else begin
      fwd_prev_reg <= fwd_q;
      rev_prev_reg <= rev_q;
    end
  end

  // A fault drops the amplifier as well as ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_en_reg <= 1'b0;
    end else begin
      amp_en_reg <= enable_q & ~fault;
    end
  end

  // Setpoint; both counters restart at zero on each enable
  always_ff @(posedge aclk) begin
    if (!aresetn || !amp_en_reg) begin
      step_pos_reg <= 32'sh0;
    end else if (ctrl_reg.step_scheme_sel) begin
      if (fwd_rise && !rev_rise) begin
        step_pos_reg <= step_pos_reg + 32'sh1;
      end else if (rev_rise && !fwd_rise) begin
        step_pos_reg <= step_pos_reg - 32'sh1;
      end
    end else if (fwd_rise) begin
      if (rev_q) begin
        step_pos_reg <= step_pos_reg - 32'sh1;
      end else begin
        step_pos_reg <= step_pos_reg + 32'sh1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !amp_en_reg) begin
      enc_pos_reg <= 32'sh0;
    end else if (enc_inc) begin
      enc_pos_reg <= enc_pos_reg + 32'sh1;
    end else if (enc_dec) begin
      enc_pos_reg <= enc_pos_reg - 32'sh1;
    end
  end

  // Cross-multiplied to avoid a divider on the angle test
  always_comb begin
    dev = PW'(enc_pos_reg) * SPR_W - PW'(step_pos_reg) * ENC_CPR_W;
    dev_abs = dev[PW-1] ? -dev : dev;
    over = (dev_abs * DDEG_W) > LIMIT_W;
  end

  // Latched until enable is withdrawn
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_q) begin
      contour_err_reg <= 1'b0;
    end else if (ctrl_reg.stall_monitor_en && amp_en_reg && over) begin
      contour_err_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !amp_en_reg) begin
      ready_cnt_reg <= 32'h0;
    end else if (ready_cnt_reg != READY_LAST) begin
      ready_cnt_reg <= ready_cnt_reg + 32'h1;
    end
  end

  assign ready_next = amp_en_reg & ~fault & (ready_cnt_reg == READY_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_reg <= 1'b0;
      ready_n_oe <= 1'b0;
      drive_ready_pos <= 1'b0;
      ready_n_out <= 1'b0;
      reserved_out <= 1'b0;
      amp_en_out <= 1'b0;
    end else begin
      ready_reg <= ready_next;
      ready_n_oe <= ready_next;
      drive_ready_pos <= ready_next;
      ready_n_out <= 1'b0;
      reserved_out <= 1'b0;
      amp_en_out <= amp_en_reg;
    end
  end

  assign evt.contour_err = contour_err_reg;
  assign evt.temp_fault = ~temp_q;
  assign evt.ready_rise = ready_next & ~ready_reg;

  logic aw_have;
  logic w_have;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  assign aw_have = ~s_axi_awready;
  assign w_have = ~s_axi_wready;
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sds_pkg::RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_reg)
          sds_pkg::OFS_CTRL, sds_pkg::OFS_CLEAR, sds_pkg::OFS_IRQ_EN,
          sds_pkg::OFS_STATE, sds_pkg::OFS_STATUS,
          sds_pkg::OFS_STEP_POS, sds_pkg::OFS_ENC_POS:
            s_axi_bresp <= sds_pkg::RESP_OKAY;
          default: s_axi_bresp <= sds_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_fire & w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= sds_pkg::CTRL_RESET;
      irq_en_reg <= sds_pkg::EVT_RESET;
    end else if (wr_lane0 && aw_addr_reg == sds_pkg::OFS_CTRL) begin
      ctrl_reg <= w_data_reg[1:0];
    end else if (wr_lane0 && aw_addr_reg == sds_pkg::OFS_IRQ_EN) begin
      irq_en_reg <= w_data_reg[2:0];
    end
  end

  always_comb begin
    clear_pulse = sds_pkg::EVT_RESET;
    if (wr_lane0 && aw_addr_reg == sds_pkg::OFS_CLEAR) begin
      clear_pulse = w_data_reg[2:0];
    end
  end

  // New event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= sds_pkg::EVT_RESET;
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clear_pulse) | evt;
      irq <= |(status_reg & irq_en_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sds_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sds_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sds_pkg::OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_reg};
        sds_pkg::OFS_STATE: s_axi_rdata <= {26'h0, enable_q, temp_q,
          contour_err_reg, ready_reg, amp_en_reg, ctrl_reg.step_scheme_sel};
        sds_pkg::OFS_STATUS: s_axi_rdata <= {29'h0, status_reg};
        sds_pkg::OFS_CLEAR: s_axi_rdata <= 32'h0;
        sds_pkg::OFS_IRQ_EN: s_axi_rdata <= {29'h0, irq_en_reg};
        sds_pkg::OFS_STEP_POS: s_axi_rdata <= step_pos_reg;
        sds_pkg::OFS_ENC_POS: s_axi_rdata <= enc_pos_reg;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= sds_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pd_cw;
    !ctrl_reg.step_scheme_sel && amp_en_reg && fwd_rise && !rev_q
      |=> step_pos_reg == $past(step_pos_reg) + 32'sh1;
  endproperty
  a_pd_cw: assert property (p_pd_cw)
    else $error("clockwise step not counted");

  property p_pd_ccw;
    !ctrl_reg.step_scheme_sel && amp_en_reg && fwd_rise && rev_q
      |=> step_pos_reg == $past(step_pos_reg) - 32'sh1;
  endproperty
  a_pd_ccw: assert property (p_pd_ccw)
    else $error("anticlockwise step not counted");

  property p_pd_dir_no_step;
    !ctrl_reg.step_scheme_sel && amp_en_reg && !fwd_rise && rev_rise
      |=> $stable(step_pos_reg);
  endproperty
  a_pd_dir_no_step: assert property (p_pd_dir_no_step)
    else $error("direction edge moved setpoint");

  property p_fr_back;
    ctrl_reg.step_scheme_sel && amp_en_reg && rev_rise && !fwd_rise
      |=> step_pos_reg == $past(step_pos_reg) - 32'sh1;
  endproperty
  a_fr_back: assert property (p_fr_back)
    else $error("backward step not counted");

  property p_amp_off;
    !enable_q |=> !amp_en_reg ##1 !amp_en_out;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier on without enable");

  property p_ready_delay;
    $rose(ready_n_oe) |-> $past(ready_cnt_reg) == READY_LAST;
  endproperty
  a_ready_delay: assert property (p_ready_delay)
    else $error("ready before delay");

  property p_ready_off;
    !amp_en_reg |=> !ready_n_oe && !ready_n_out;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready pulled while disabled");

  property p_ready_pair;
    drive_ready_pos == ready_n_oe && !reserved_out;
  endproperty
  a_ready_pair: assert property (p_ready_pair)
    else $error("ready pair or reserved output wrong");

  property p_enc_count;
    amp_en_reg && enc_inc |=> enc_pos_reg == $past(enc_pos_reg) + 32'sh1;
  endproperty
  a_enc_count: assert property (p_enc_count)
    else $error("encoder count missed");

  property p_contour;
    ctrl_reg.stall_monitor_en && amp_en_reg && over && enable_q
      |=> contour_err_reg ##1 status_reg.contour_err;
  endproperty
  a_contour: assert property (p_contour)
    else $error("contouring error not raised");

  property p_mon_off;
    $rose(contour_err_reg) |-> $past(ctrl_reg.stall_monitor_en);
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("error raised with monitor off");

  property p_temp;
    !temp_q |=> status_reg.temp_fault && !ready_reg;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature fault not reported");

  c_ready: cover property ($rose(ready_n_oe));
  c_contour: cover property ($rose(contour_err_reg));
  c_fr_step: cover property (ctrl_reg.step_scheme_sel && fwd_rise);
  c_irq: cover property ($rose(irq));
endmodule : sds_step_dir_monitor
`default_nettype wire

// ==== tb/sds_ext_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module sds_ext_ctrl #(
  parameter int HALF = 100
) (
  input wire logic aclk,
  output logic fwd_step_in_p,
  output logic fwd_step_in_n,
  output logic rev_step_in_p,
  output logic rev_step_in_n,
  output logic enable_in_p,
  output logic enable_in_n,
  output logic enc_a_p,
  output logic enc_a_n,
  output logic enc_b_p,
  output logic enc_b_n
);
  logic fwd_lvl = 1'b0;
  logic rev_lvl = 1'b0;
  logic en_lvl = 1'b0;
  int ph = 0;
  // Each step level leaves with its inverted companion; enable does not
  assign fwd_step_in_p = fwd_lvl;
  assign fwd_step_in_n = ~fwd_lvl;
  assign rev_step_in_p = rev_lvl;
  assign rev_step_in_n = ~rev_lvl;
  // Idle enable left open, both wires low
  assign enable_in_p = en_lvl;
  assign enable_in_n = 1'b0;
  // Gray order, A leads B when counting up
  assign enc_a_p = (ph[1:0] == 2'h1) || (ph[1:0] == 2'h2);
  assign enc_b_p = ph[1];
  assign enc_a_n = ~enc_a_p;
  assign enc_b_n = ~enc_b_p;
  // Half period of 100 cycles keeps steps at or under 200 kHz
  task automatic pulse(input bit back);
    if (back) rev_lvl <= 1'b1;
    else fwd_lvl <= 1'b1;
    repeat (HALF) @(posedge aclk);
    if (back) rev_lvl <= 1'b0;
    else fwd_lvl <= 1'b0;
    repeat (HALF) @(posedge aclk);
  endtask : pulse
  // Direction settles a half period before the step
  task automatic set_dir(input bit d);
    rev_lvl <= d;
    repeat (HALF) @(posedge aclk);
  endtask : set_dir
  task automatic set_en(input bit e);
    en_lvl <= e;
  endtask : set_en
  task automatic enc_move(input int n);
    repeat (n < 0 ? -n : n) begin
      ph <= ph + (n < 0 ? -1 : 1);
      repeat (4) @(posedge aclk);
    end
  endtask : enc_move
endmodule : sds_ext_ctrl
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk;
  logic aresetn;
  logic winding_temp_ok;
  logic fwd_step_in_p, fwd_step_in_n, rev_step_in_p, rev_step_in_n;
  logic enable_in_p, enable_in_n, enc_a_p, enc_a_n, enc_b_p, enc_b_n;
  logic amp_en_out, ready_n_out, ready_n_oe, drive_ready_pos;
  logic reserved_out, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] s_axi_awaddr;
  logic [7:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid;
  logic s_axi_wvalid;
  logic s_axi_bready;
  logic s_axi_arvalid;
  logic s_axi_rready;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h71599215;
  int sc = 0;
  int ec = 0;
  bit dir;
  logic [31:0] rd;
  logic [1:0] rs;
  // Open-collector pin pulled high unless driven
  wire ready_pin = ready_n_oe ? ready_n_out : 1'b1;

  always #12.5 aclk = ~aclk;

  sds_step_dir_monitor #(.READY_DELAY_CYC(20), .STEPS_PER_REV(1000))
    i_sds_step_dir_monitor (.aclk, .aresetn, .fwd_step_in_p,
    .fwd_step_in_n, .rev_step_in_p, .rev_step_in_n, .enable_in_p,
    .enable_in_n, .enc_a_p, .enc_a_n, .enc_b_p, .enc_b_n,
    .winding_temp_ok, .amp_en_out, .ready_n_out, .ready_n_oe,
    .drive_ready_pos, .reserved_out, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  sds_ext_ctrl i_sds_ext_ctrl (.aclk, .fwd_step_in_p, .fwd_step_in_n,
    .rev_step_in_p, .rev_step_in_n, .enable_in_p, .enable_in_n,
    .enc_a_p, .enc_a_n, .enc_b_p, .enc_b_n);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bchk(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : bchk

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // No cycle limit here: only the watchdog ends a hung transfer
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd, rs);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, sds_pkg::RESP_OKAY});
  endtask : rchk

  initial begin
    cyc(50000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    winding_temp_ok = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    cyc(20);
    aresetn <= 1'b1;
    cyc(10);
    bchk(reserved_out, 1'b0);
    bchk(amp_en_out, 1'b0);
    bchk(ready_pin, 1'b1);
    rchk(sds_pkg::OFS_CTRL, 32'h2);
    // Lane zero off: the write is answered but must not land
    s_axi_wstrb <= 4'hE;
    wr(sds_pkg::OFS_CTRL, 32'h1, rs);
    s_axi_wstrb <= 4'hF;
    chk({30'h0, rs}, {30'h0, sds_pkg::RESP_OKAY});
    rchk(sds_pkg::OFS_CTRL, 32'h2);
    // Synchronisers start low, so the temperature flag may be set
    wr(sds_pkg::OFS_CLEAR, 32'h7, rs);
    rchk(sds_pkg::OFS_STATUS, 32'h0);
    rd_reg(8'h40, rd, rs);
    chk({30'h0, rs}, {30'h0, sds_pkg::RESP_SLVERR});
    wr(8'h44, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, sds_pkg::RESP_SLVERR});
    $display("test reset done");
    i_sds_ext_ctrl.set_en(1'b1);
    cyc(8);
    bchk(amp_en_out, 1'b1);
    bchk(drive_ready_pos, 1'b0);
    cyc(40);
    bchk(ready_pin, 1'b0);
    bchk(drive_ready_pos, 1'b1);
    rchk(sds_pkg::OFS_STATUS, 32'h4);
    rchk(sds_pkg::OFS_STATE, 32'h36);
    $display("test enable done");
    for (int i = 0; i < 12; i++) begin
      dir = 1'($random(seed));
      i_sds_ext_ctrl.set_dir(dir);
      i_sds_ext_ctrl.pulse(1'b0);
      i_sds_ext_ctrl.enc_move(dir ? -4 : 4);
      sc += dir ? -1 : 1;
      ec += dir ? -4 : 4;
    end
    i_sds_ext_ctrl.set_dir(1'b0);
    cyc(10);
    rchk(sds_pkg::OFS_STEP_POS, 32'(sc));
    rchk(sds_pkg::OFS_ENC_POS, 32'(ec));
    $display("test pulse_dir done");
    wr(sds_pkg::OFS_CTRL, 32'h3, rs);
    for (int i = 0; i < 8; i++) begin
      i_sds_ext_ctrl.pulse(i % 3 == 0);
      sc += (i % 3 == 0) ? -1 : 1;
    end
    cyc(10);
    rchk(sds_pkg::OFS_STEP_POS, 32'(sc));
    i_sds_ext_ctrl.enc_move(8);
    $display("test fwd_rev done");
    wr(sds_pkg::OFS_CTRL, 32'h1, rs);
    i_sds_ext_ctrl.enc_move(80);
    cyc(10);
    bchk(amp_en_out, 1'b1);
    i_sds_ext_ctrl.enc_move(-80);
    wr(sds_pkg::OFS_CTRL, 32'h3, rs);
    wr(sds_pkg::OFS_IRQ_EN, 32'h1, rs);
    rchk(sds_pkg::OFS_IRQ_EN, 32'h1);
    // 71 counts stays under 6.4 degrees, 72 goes over
    i_sds_ext_ctrl.enc_move(71);
    cyc(10);
    bchk(irq, 1'b0);
    bchk(amp_en_out, 1'b1);
    i_sds_ext_ctrl.enc_move(1);
    cyc(10);
    bchk(irq, 1'b1);
    bchk(drive_ready_pos, 1'b0);
    i_sds_ext_ctrl.set_en(1'b0);
    cyc(10);
    wr(sds_pkg::OFS_CLEAR, 32'h7, rs);
    cyc(3);
    bchk(irq, 1'b0);
    $display("test contour done");
    i_sds_ext_ctrl.set_en(1'b1);
    cyc(40);
    bchk(drive_ready_pos, 1'b1);
    winding_temp_ok <= 1'b0;
    cyc(10);
    bchk(amp_en_out, 1'b0);
    rchk(sds_pkg::OFS_STATUS, 32'h6);
    winding_temp_ok <= 1'b1;
    i_sds_ext_ctrl.set_en(1'b0);
    cyc(10);
    bchk(ready_pin, 1'b1);
    bchk(drive_ready_pos, 1'b0);
    $display("test temperature done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
